// ---- hw/pxbs_status_reg.sv ----
// Overview of operation
// RULE1: the function number field is read only and reads as zero after reset.
// RULE2: every write addressing the bridge loads the device number from address bits 15:11.
// RULE3: a write addresses the bridge only with write command, idsel, type-0 and matching function.
// RULE4: the bus number field reads the primary bus number held in the type-1 header.
// RULE5: the completer id for split completions is built from bus, device and function numbers.
// RULE6: the same identity is used whatever mix of conventional and PCI-X modes is running.
// RULE7: the 64-bit capability bit is read only and zero.
// RULE8: the 133 MHz capable bit is zero in forward mode and one in reverse mode.
// RULE9: split completion discarded and overrun bits are read only and zero.
// RULE10: a split completion carrying our own id sets a write-one-to-clear flag, locked in reverse.
// RULE11: a split request that would pass the commitment limit is held back and sets a sticky flag.
// RULE12: the downstream commitment limit is a writable 16-bit field resetting to 0010h.
// RULE13: bits 31:22 read as zero and ignore writes.
`default_nettype none
module pxbs_status_reg
    import pxbs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reverse_strap,
    input wire logic cfg_req,
    input wire logic [3:0] cfg_cmd,
    input wire logic cfg_idsel,
    input wire logic [31:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic [7:0] pri_bus_number,
    input wire logic sc_valid,
    input wire logic [15:0] sc_requester_id,
    input wire logic split_req_valid,
    input wire logic [15:0] split_req_adq,
    input wire logic [15:0] split_outstanding_adq,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    output logic [15:0] completer_id,
    output logic split_req_fwd,
    output logic split_req_held,
    output logic reverse_mode
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bridge identity word, shared by completer id and requester id match
    function automatic logic [15:0] pxbs_id(input logic [7:0] bus, input logic [4:0] dev,
                                            input logic [2:0] fn);
        pxbs_id = {bus, dev, fn};
    endfunction : pxbs_id

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic strap_sync1_reg;
    logic strap_sync2_reg;
    logic reverse_reg;
    pxbs_strap_t strap_st_reg;

    // strap is a pin, so it is synchronised before anyone looks at it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync1_reg <= 1'b0;
            strap_sync2_reg <= 1'b0;
        end else begin
            strap_sync1_reg <= reverse_strap;
            strap_sync2_reg <= strap_sync1_reg;
        end
    end

    // the mode is caught once after release and then frozen; the second
    // synchroniser stage only holds the pin from the second edge on, so wait two
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_st_reg <= PXBS_ST_SYNC;
            reverse_reg <= 1'b0;
        end else begin
            case (strap_st_reg)
                PXBS_ST_SYNC: begin
                    strap_st_reg <= PXBS_ST_SETTLE;
                end
                PXBS_ST_SETTLE: begin
                    strap_st_reg <= PXBS_ST_LATCH;
                end
                PXBS_ST_LATCH: begin
                    reverse_reg <= strap_sync2_reg;
                    strap_st_reg <= PXBS_ST_RUN;
                end
                PXBS_ST_RUN: begin
                    strap_st_reg <= PXBS_ST_RUN;
                end
                default: begin
                    strap_st_reg <= PXBS_ST_SYNC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic [2:0] func_num_reg;
    logic [4:0] dev_num_reg;
    logic [15:0] dn_limit_reg;
    logic addressed;
    logic [7:0] reg_off;
    logic hit_status;
    logic hit_limit;
    logic cfg_rd;

    assign addressed = cfg_req && (cfg_cmd == PXBS_CMD_CFG_WRITE) && cfg_idsel // [RULE3]
        && (cfg_addr[1:0] == PXBS_TYPE0)
        && (cfg_addr[PXBS_ADDR_FUNC_LSB +: 3] == func_num_reg);
    assign reg_off = {cfg_addr[7:2], 2'b00};
    assign hit_status = addressed && (reg_off == PXBS_OFF_STATUS);
    assign hit_limit = addressed && (reg_off == PXBS_OFF_DN_SPLIT);
    assign cfg_rd = cfg_req && (cfg_cmd != PXBS_CMD_CFG_WRITE) && cfg_idsel
        && (cfg_addr[1:0] == PXBS_TYPE0)
        && (cfg_addr[PXBS_ADDR_FUNC_LSB +: 3] == func_num_reg);

    // function number is fixed for a single-function bridge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            func_num_reg <= PXBS_FUNC_RST; // [RULE1]
        end else begin
            func_num_reg <= PXBS_FUNC_RST; // [RULE1]
        end
    end

    // any write that reaches us, whatever register it targets, refreshes the device number
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_num_reg <= PXBS_DEV_RST;
        end else if (addressed) begin
            dev_num_reg <= cfg_addr[PXBS_ADDR_DEV_LSB +: 5]; // [RULE2]
        end
    end

    // downstream commitment limit, byte lanes 2 and 3
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dn_limit_reg <= PXBS_LIMIT_RST; // [RULE12]
        end else if (hit_limit) begin
            if (cfg_byte_en[2]) begin
                dn_limit_reg[7:0] <= cfg_wdata[PXBS_LIMIT_LSB +: 8]; // [RULE12]
            end
            if (cfg_byte_en[3]) begin
                dn_limit_reg[15:8] <= cfg_wdata[PXBS_LIMIT_LSB + 8 +: 8]; // [RULE12]
            end
        end
    end

    // ------------------------------------------------------------
    // sticky split flags
    // ------------------------------------------------------------
    pxbs_flag_if #(.N(PXBS_NFLAGS)) flags ();
    logic [15:0] own_id;
    logic would_exceed;
    logic [16:0] commit_sum;
    logic w1c_lane;

    assign own_id = pxbs_id(pri_bus_number, dev_num_reg, func_num_reg); // [RULE6]
    assign w1c_lane = hit_status && cfg_byte_en[2];
    // 17 bits so the sum cannot wrap past the limit; all ones means no limit at all
    assign commit_sum = {1'b0, split_outstanding_adq} + {1'b0, split_req_adq};
    assign would_exceed = (dn_limit_reg != PXBS_LIMIT_UNBOUNDED) // [RULE11]
        && (commit_sum > {1'b0, dn_limit_reg});

    assign flags.set[PXBS_FLG_USC] = sc_valid && (sc_requester_id == own_id); // [RULE10]
    assign flags.clr[PXBS_FLG_USC] = w1c_lane && cfg_wdata[PXBS_BIT_USC]; // [RULE10]
    assign flags.lock[PXBS_FLG_USC] = reverse_reg; // [RULE10]
    assign flags.set[PXBS_FLG_SRD] = split_req_valid && would_exceed; // [RULE11]
    assign flags.clr[PXBS_FLG_SRD] = w1c_lane && cfg_wdata[PXBS_BIT_SRD]; // [RULE11]
    assign flags.lock[PXBS_FLG_SRD] = 1'b0;

    pxbs_w1c_bank #(.N(PXBS_NFLAGS)) u_flags (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flg(flags)
    );

    // ------------------------------------------------------------
    // split request gate
    // ------------------------------------------------------------
    // the verdict is a registered pulse; the request source waits one cycle for it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            split_req_fwd <= 1'b0;
            split_req_held <= 1'b0;
        end else begin
            split_req_fwd <= split_req_valid && !would_exceed;
            split_req_held <= split_req_valid && would_exceed; // [RULE11]
        end
    end

    // ------------------------------------------------------------
    // identity outputs
    // ------------------------------------------------------------
    // one identity for every mode pairing, so no per-interface copy is kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            completer_id <= pxbs_id(8'h00, PXBS_DEV_RST, PXBS_FUNC_RST);
        end else begin
            completer_id <= own_id; // [RULE5]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reverse_mode <= 1'b0;
        end else begin
            reverse_mode <= reverse_reg;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] limit_word;
    logic cap133;

    // before the strap settles the forward value shows
    assign cap133 = reverse_reg ? PXBS_133_REV : PXBS_133_FWD; // [RULE8]

    always_comb begin
        status_word = 32'h0000_0000; // [RULE13]
        status_word[PXBS_FUNC_LSB +: 3] = func_num_reg; // [RULE1]
        status_word[PXBS_DEV_LSB +: 5] = dev_num_reg;
        status_word[PXBS_BUS_LSB +: 8] = pri_bus_number; // [RULE4]
        status_word[PXBS_BIT_64B] = PXBS_64B_RST; // [RULE7]
        status_word[PXBS_BIT_133] = cap133; // [RULE8]
        status_word[PXBS_BIT_SCD] = PXBS_SC_RO_RST; // [RULE9]
        status_word[PXBS_BIT_USC] = flags.q[PXBS_FLG_USC];
        status_word[PXBS_BIT_SCO] = PXBS_SC_RO_RST; // [RULE9]
        status_word[PXBS_BIT_SRD] = flags.q[PXBS_FLG_SRD];
    end

    always_comb begin
        limit_word = {dn_limit_reg, PXBS_CAP_ADQ};
    end

    // one-cycle answer to every access that reaches the bridge; other offsets read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack <= addressed || cfg_rd;
            if (cfg_rd && (reg_off == PXBS_OFF_STATUS)) begin
                cfg_rdata <= status_word;
            end else if (cfg_rd && (reg_off == PXBS_OFF_DN_SPLIT)) begin
                cfg_rdata <= limit_word;
            end else begin
                cfg_rdata <= 32'h0000_0000;
            end
        end
    end
endmodule : pxbs_status_reg
`default_nettype wire

// ---- inc/pxbs_pkg.sv ----
`default_nettype none
package pxbs_pkg;
    // ------------------------------------------------------------
    // configuration space layout
    // ------------------------------------------------------------
    localparam logic [7:0] PXBS_OFF_STATUS = 8'h84;
    localparam logic [7:0] PXBS_OFF_DN_SPLIT = 8'h8c;
    localparam logic [3:0] PXBS_CMD_CFG_WRITE = 4'hb;
    localparam logic [1:0] PXBS_TYPE0 = 2'h0;

    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int PXBS_FUNC_LSB = 0;
    localparam int PXBS_DEV_LSB = 3;
    localparam int PXBS_BUS_LSB = 8;
    localparam int PXBS_BIT_64B = 16;
    localparam int PXBS_BIT_133 = 17;
    localparam int PXBS_BIT_SCD = 18;
    localparam int PXBS_BIT_USC = 19;
    localparam int PXBS_BIT_SCO = 20;
    localparam int PXBS_BIT_SRD = 21;
    localparam int PXBS_LIMIT_LSB = 16;
    localparam int PXBS_ADDR_FUNC_LSB = 8;
    localparam int PXBS_ADDR_DEV_LSB = 11;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [2:0] PXBS_FUNC_RST = 3'h0;
    localparam logic [4:0] PXBS_DEV_RST = 5'h1f;
    localparam logic PXBS_64B_RST = 1'b0;
    localparam logic PXBS_133_FWD = 1'b0;
    localparam logic PXBS_133_REV = 1'b1;
    localparam logic PXBS_SC_RO_RST = 1'b0;
    localparam logic [15:0] PXBS_LIMIT_RST = 16'h0010;
    localparam logic [15:0] PXBS_CAP_ADQ = 16'h0010;
    localparam logic [15:0] PXBS_LIMIT_UNBOUNDED = 16'hffff;

    // flag bank slots
    localparam int PXBS_NFLAGS = 2;
    localparam int PXBS_FLG_USC = 0;
    localparam int PXBS_FLG_SRD = 1;

    // strap capture sequence
    typedef enum logic [1:0] {
        PXBS_ST_SYNC,
        PXBS_ST_SETTLE,
        PXBS_ST_LATCH,
        PXBS_ST_RUN
    } pxbs_strap_t;
endpackage : pxbs_pkg
`default_nettype wire

// ---- inc/pxbs_flag_if.sv ----
`default_nettype none
// sticky write-one-to-clear flags shared between the register file and its bank
interface pxbs_flag_if #(parameter int unsigned N = 2);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] lock;
    logic [N-1:0] q;
    modport bank (input set, input clr, input lock, output q);
    modport user (output set, output clr, output lock, input q);
endinterface : pxbs_flag_if
`default_nettype wire

// ---- hw/pxbs_w1c_bank.sv ----
`default_nettype none
module pxbs_w1c_bank #(
    parameter int unsigned N = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    pxbs_flag_if.bank flg
);
    // ------------------------------------------------------------
    // one sticky cell per flag
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_cell
            // set beats clear so an event in the clearing cycle survives
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flg.q[i] <= 1'b0;
                end else if (flg.set[i]) begin
                    flg.q[i] <= 1'b1;
                end else if (flg.clr[i] && !flg.lock[i]) begin
                    flg.q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : pxbs_w1c_bank
`default_nettype wire

// ---- testbench/pxbs_status_reg_asserts.sv ----
`default_nettype none
module pxbs_status_reg_asserts
    import pxbs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cfg_req,
    input wire logic [3:0] cfg_cmd,
    input wire logic cfg_idsel,
    input wire logic [31:0] cfg_addr,
    input wire logic [7:0] pri_bus_number,
    input wire logic split_req_valid,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic [15:0] completer_id,
    input wire logic split_req_fwd,
    input wire logic split_req_held,
    input wire logic reverse_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // port relations
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic hit;
    // type-0 access aimed at our function
    assign hit = cfg_req && cfg_idsel && cfg_addr[1:0] == 2'h0 && cfg_addr[10:8] == 3'h0;
    sequence s_rd84;
        cfg_ack && $past(cfg_addr[7:0]) == PXBS_OFF_STATUS && $past(cfg_cmd) != PXBS_CMD_CFG_WRITE;
    endsequence
    property p_ack; hit |=> cfg_ack; endproperty
    a_ack: assert property (p_ack) else $error("matched access not acked");
    property p_nak; !hit |=> !cfg_ack; endproperty
    a_nak: assert property (p_nak) else $error("foreign access acked");
    property p_dev;
        hit && cfg_cmd == PXBS_CMD_CFG_WRITE |=> ##1 completer_id[7:3] == $past(cfg_addr[15:11], 2);
    endproperty
    a_dev: assert property (p_dev) else $error("device number not loaded");
    property p_ans; split_req_valid |=> split_req_fwd != split_req_held; endproperty
    a_ans: assert property (p_ans) else $error("split request not answered once");
    property p_quiet; !split_req_valid |=> !split_req_fwd && !split_req_held; endproperty
    a_quiet: assert property (p_quiet) else $error("split answer without request");
    property p_cid;
        $past(rst_n) |-> completer_id[15:8] == $past(pri_bus_number) && completer_id[2:0] == 3'h0;
    endproperty
    a_cid: assert property (p_cid) else $error("completer id wrong");
    property p_fix;
        s_rd84 |-> cfg_rdata[2:0] == 3'h0 && !cfg_rdata[16] && !cfg_rdata[18] && !cfg_rdata[20]
            && cfg_rdata[31:22] == 10'h000;
    endproperty
    a_fix: assert property (p_fix) else $error("fixed bits wrong");
    property p_bus;
        s_rd84 |-> cfg_rdata[15:8] == $past(pri_bus_number) && cfg_rdata[7:3] == completer_id[7:3];
    endproperty
    a_bus: assert property (p_bus) else $error("bus or device field wrong");
    property p_133; s_rd84 |-> cfg_rdata[17] == reverse_mode; endproperty
    a_133: assert property (p_133) else $error("speed bit wrong");
    c_wr: cover property (hit && cfg_cmd == PXBS_CMD_CFG_WRITE);
    c_held: cover property (split_req_held);
    c_rev: cover property (s_rd84 ##0 reverse_mode);
endmodule : pxbs_status_reg_asserts
bind pxbs_status_reg pxbs_status_reg_asserts i_pxbs_status_reg_asserts (.core_clk, .rst_n,
    .cfg_req, .cfg_cmd, .cfg_idsel, .cfg_addr, .pri_bus_number, .split_req_valid, .cfg_ack,
    .cfg_rdata, .completer_id, .split_req_fwd, .split_req_held, .reverse_mode);
`default_nettype wire

// ---- testbench/pxbs_cfg_master.sv ----
`default_nettype none
module pxbs_cfg_master (
    input wire logic core_clk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_req,
    output logic [3:0] cfg_cmd,
    output logic cfg_idsel,
    output logic [31:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cfg_req, cfg_cmd, cfg_idsel, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
    // one-cycle pulse; idsel, address and write data are inverted after so nothing stale reads back
    task access(input logic [3:0] cmd, input logic sel, input logic [31:0] addr,
        input logic [3:0] be, input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        @(posedge core_clk);
        cfg_req <= 1'b1;
        cfg_cmd <= cmd;
        cfg_idsel <= sel;
        cfg_addr <= addr;
        cfg_byte_en <= be;
        cfg_wdata <= wd;
        @(posedge core_clk);
        cfg_req <= 1'b0;
        cfg_idsel <= ~sel;
        cfg_addr <= ~addr;
        cfg_wdata <= ~wd;
        #1;
        ack = cfg_ack;
        rd = cfg_rdata;
    endtask : access
endmodule : pxbs_cfg_master
`default_nettype wire

// ---- testbench/pxbs_status_reg_bench.sv ----
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module pxbs_status_reg_bench
    import pxbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, reverse_strap, sc_valid, split_req_valid, cfg_req, cfg_idsel, cfg_ack;
    logic split_req_fwd, split_req_held, reverse_mode, usc_m, srd_m, rev_m, ack;
    logic [3:0] cfg_cmd, cfg_byte_en;
    logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, seed, r, rd;
    logic [7:0] pri_bus_number;
    logic [15:0] sc_requester_id, split_req_adq, split_outstanding_adq, completer_id, lim_m;
    logic [4:0] dev_m;
    int miscompares, comparisons, cycles;
    pxbs_status_reg i_pxbs_status_reg (.core_clk, .rst_n, .reverse_strap, .cfg_req, .cfg_cmd,
        .cfg_idsel, .cfg_addr, .cfg_byte_en, .cfg_wdata, .pri_bus_number, .sc_valid,
        .sc_requester_id, .split_req_valid, .split_req_adq, .split_outstanding_adq, .cfg_ack,
        .cfg_rdata, .completer_id, .split_req_fwd, .split_req_held, .reverse_mode);
    pxbs_cfg_master i_pxbs_cfg_master (.core_clk, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_cmd,
        .cfg_idsel, .cfg_addr, .cfg_byte_en, .cfg_wdata);
    // ----
    // helpers
    // ----
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function logic [31:0] st_exp();
        return {10'h0, srd_m, 1'b0, usc_m, 1'b0, rev_m, 1'b0, pri_bus_number, dev_m, 3'h0};
    endfunction : st_exp
    // 17-bit sum so a wrap never hides an overrun
    function logic held_exp(input logic [15:0] a, input logic [15:0] o);
        return lim_m != 16'hffff && ({1'b0, a} + {1'b0, o}) > {1'b0, lim_m};
    endfunction : held_exp
    task conclude();
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] wd);
        i_pxbs_cfg_master.access(PXBS_CMD_CFG_WRITE, 1'b1, a, be, wd, ack, rd);
    endtask : wr
    task rd_chk(input logic [7:0] off, input logic [31:0] e);
        i_pxbs_cfg_master.access(4'ha, 1'b1, {24'h0, off}, 4'hf, 32'h0, ack, rd);
        `CHK(rd, e)
    endtask : rd_chk
    task split(input logic [15:0] a, input logic [15:0] o);
        logic h;
        h = held_exp(a, o);
        @(posedge core_clk);
        split_req_valid <= 1'b1;
        split_req_adq <= a;
        split_outstanding_adq <= o;
        @(posedge core_clk);
        split_req_valid <= 1'b0;
        split_req_adq <= ~a;
        #1;
        `CHK({split_req_fwd, split_req_held}, {!h, h})
        srd_m = srd_m | h;
    endtask : split
    task sc(input logic [15:0] id);
        @(posedge core_clk);
        sc_valid <= 1'b1;
        sc_requester_id <= id;
        @(posedge core_clk);
        sc_valid <= 1'b0;
        sc_requester_id <= ~id;
    endtask : sc
    // strap settles during reset, then the capture sequence needs a few edges
    task do_reset(input logic strap);
        @(posedge core_clk);
        rst_n <= 1'b0;
        reverse_strap <= strap;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        {dev_m, usc_m, srd_m, rev_m, lim_m} = {5'h1f, 1'b0, 1'b0, strap, PXBS_LIMIT_RST};
    endtask : do_reset
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        {rst_n, reverse_strap, sc_valid, split_req_valid} = '0;
        {sc_requester_id, split_req_adq, split_outstanding_adq} = '0;
        {miscompares, comparisons, cycles} = '0;
        seed = 32'h8f75_7ec1;
        pri_bus_number = 8'h3c;
        do_reset(1'b0);
        rd_chk(PXBS_OFF_STATUS, st_exp());
        rd_chk(PXBS_OFF_DN_SPLIT, {lim_m, 16'h0010});
        // writes to unrelated offsets still move the device number
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            dev_m = r[15:11];
            @(posedge core_clk);
            pri_bus_number <= r[23:16];
            wr({16'h0, r[15:11], 5'h00, r[5:2], 2'h0}, 4'hf, rnd());
            `CHK(ack, 1'b1)
            rd_chk(PXBS_OFF_STATUS, st_exp());
        end
        // no idsel, type 1, wrong function numbers
        for (int i = 0; i < 4; i++) begin
            i_pxbs_cfg_master.access(PXBS_CMD_CFG_WRITE, i != 0, {16'h0, 5'h05,
                i == 2 ? 3'h1 : (i == 3 ? 3'h7 : 3'h0), 6'h21, i == 1 ? 2'h1 : 2'h0},
                4'hf, 32'hffff_ffff, ack, rd);
            `CHK(ack, 1'b0)
        end
        rd_chk(PXBS_OFF_STATUS, st_exp());
        sc({pri_bus_number, ~dev_m, 3'h0});
        sc({pri_bus_number, dev_m, 3'h0});
        usc_m = 1'b1;
        split(16'h0009, 16'h0008);
        split(16'h0008, 16'h0008);
        rd_chk(PXBS_OFF_STATUS, st_exp());
        wr(32'h0000_5084, 4'hb, 32'hffff_ffff);
        dev_m = 5'h0a;
        rd_chk(PXBS_OFF_STATUS, st_exp());
        wr(32'h0000_5084, 4'hf, 32'hffff_ffff);
        {usc_m, srd_m} = 2'b00;
        rd_chk(PXBS_OFF_STATUS, st_exp());
        // random limit and requests around it
        r = rnd();
        lim_m = {6'h0, r[9:0]};
        wr(32'h0000_508c, 4'hc, {lim_m, r[31:16]});
        rd_chk(PXBS_OFF_DN_SPLIT, {lim_m, 16'h0010});
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            split({7'h0, r[8:0]}, {7'h0, r[24:16]});
        end
        rd_chk(PXBS_OFF_STATUS, st_exp());
        lim_m = 16'hffff;
        wr(32'h0000_508c, 4'hc, 32'hffff_0000);
        split(16'hffff, 16'hffff);
        // reverse mode after a mid-run reset: flag clear is ignored
        do_reset(1'b1);
        rd_chk(PXBS_OFF_STATUS, st_exp());
        sc({pri_bus_number, dev_m, 3'h0});
        usc_m = 1'b1;
        wr(32'h0000_f884, 4'hf, 32'hffff_ffff);
        rd_chk(PXBS_OFF_STATUS, st_exp());
        conclude();
    end
endmodule : pxbs_status_reg_bench
`default_nettype wire
